// ---- design/dps_pkg.sv ----
// shared constants for the synchronous dual-port ram port
package dps_pkg;
  localparam int DPS_DATA_W = 18;          // word width
  localparam int DPS_LANE_W = 9;           // bits per byte lane
  localparam int DPS_LANES = 2;            // lanes per word
  localparam int DPS_ADDR_W = 18;          // address pins
  localparam int DPS_LOW_LANE_LSB = 0;     // low lane starts at bit 0
  localparam int DPS_HIGH_LANE_LSB = 9;    // high lane starts at bit 9
  localparam logic [DPS_ADDR_W-1:0] DPS_ADDR_RST = 18'h00000;
  localparam logic [DPS_DATA_W-1:0] DPS_DATA_RST = 18'h00000;
  localparam logic [DPS_LANES-1:0] DPS_LANE_RST = 2'h0;
  localparam logic DPS_PDOWN_RST = 1'b1;   // deselected after reset
endpackage

// ---- design/dps_mem.sv ----
// word array with per-lane write and registered read data
`timescale 1ns/100ps
module dps_mem
  import dps_pkg::*;
#(
  parameter int AW = DPS_ADDR_W,
  parameter int DW = DPS_DATA_W
)
(
  input wire logic clk,                  // port clock
  input wire logic ce,                   // clock enable
  input wire logic [AW-1:0] addr,        // word address
  input wire logic [DPS_LANES-1:0] laneWe, // write strobe per lane
  input wire logic re,                   // read strobe
  input wire logic [DW-1:0] wdata,       // write data
  output logic [DW-1:0] rdata            // registered read data
);
  // lane slices come from the package, so the word width is fixed
  if (DW != DPS_DATA_W)
  begin : g_bad_width
    $error("dps_mem: DW must equal the package word width");
  end

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // lane writes and registered read; no reset on array or read data
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (laneWe[0])
        mem[addr][DPS_HIGH_LANE_LSB-1:DPS_LOW_LANE_LSB] <=
          wdata[DPS_HIGH_LANE_LSB-1:DPS_LOW_LANE_LSB];
      if (laneWe[1])
        mem[addr][DW-1:DPS_HIGH_LANE_LSB] <= wdata[DW-1:DPS_HIGH_LANE_LSB];
      if (re)
        rdata <= mem[addr];
    end
  end
endmodule // dps_mem

// ---- design/dps_port.sv ----
// one port of a synchronous dual-port ram with burst address counter
// Functional notes
// - chip deselected at edge: no access, both lanes float, power down
// - high lane enable owns bits 9..17, low lane enable owns bits 0..8
// - selected write stores data only into lanes whose enable is low
// - selected read with output enable low drives only enabled lanes
// - output enable acts without clock; high forces both lanes to float
// - strobe low, rewind high: use external address and load counter
// - strobe, advance and rewind high: reuse previous internal address
// - strobe high, advance low, rewind high: use previous address plus one
// - rewind low: counter returns to last strobed address, other inputs ignored
// - rewind target undefined at power-up; every strobe load updates it
// - strobe and rewind act even while the port is deselected
// - counter advances on advance low regardless of selects and lanes
// - pipelined read data appears one cycle after flow-through data
// - pipelined mode double-registers selects and lane enables
`timescale 1ns/100ps
module dps_port
  import dps_pkg::*;
#(
  parameter int ADDR_USED = DPS_ADDR_W   // 18, or 17 on the smaller variant
)
(
  input wire logic clk,                          // port clock
  input wire logic nrst,                         // async reset, active low
  input wire logic ce,                           // clock enable
  input wire logic outputModeSelect,             // 1 pipelined, 0 flow
  input wire logic chipSelectN,                  // chip select, low active
  input wire logic chipSelectP,                  // chip select, high active
  input wire logic readWrite,                    // 1 read, 0 write
  input wire logic outputEnableN,                // async output enable
  input wire logic highLaneEnableN,              // bits 17..9 enable
  input wire logic lowLaneEnableN,               // bits 8..0 enable
  input wire logic addressLoadStrobeN,           // load external address
  input wire logic counterAdvanceEnableN,        // advance counter
  input wire logic counterRewindN,               // return to last load
  input wire logic [DPS_ADDR_W-1:0] wordAddress, // external address
  input wire logic [DPS_DATA_W-1:0] dataLinesIn, // data pins, input side
  output logic [DPS_DATA_W-1:0] dataLinesOut,    // data pins, output side
  output logic [DPS_DATA_W-1:0] dataLinesOe,     // per-bit drive enable
  output logic [DPS_ADDR_W-1:0] currentAddress,  // internal address used
  output logic powerDown                         // port deselected
);
  // refuse address widths the counter cannot serve
  if (ADDR_USED != DPS_ADDR_W && ADDR_USED != DPS_ADDR_W - 1)
  begin : g_bad_width
    $error("dps_port: ADDR_USED must be 17 or 18");
  end

  // clears address bit 17, which the smaller variant leaves unconnected
  function automatic logic [DPS_ADDR_W-1:0] maskAddr(
    input logic [DPS_ADDR_W-1:0] a);
    logic [DPS_ADDR_W-1:0] m;
    m = '1;
    if (ADDR_USED < DPS_ADDR_W)
      m[DPS_ADDR_W-1] = 1'b0;
    return a & m;
  endfunction

  logic selected;
  logic doRead;
  logic doWrite;
  logic [DPS_LANES-1:0] laneOn;
  logic [DPS_LANES-1:0] laneWe;
  logic [DPS_LANES-1:0] laneRead;
  logic [DPS_ADDR_W-1:0] maskedAddr;
  logic [DPS_ADDR_W-1:0] rewindAddr;
  logic [DPS_ADDR_W-1:0] next_rewindAddr;
  logic [DPS_ADDR_W-1:0] addrUsed;
  logic [DPS_ADDR_W-1:0] next_currentAddress;
  logic [DPS_LANES-1:0] driveStage1;
  logic [DPS_LANES-1:0] driveStage2;
  logic [DPS_LANES-1:0] next_driveStage1;
  logic [DPS_LANES-1:0] next_driveStage2;
  logic [DPS_LANES-1:0] laneDrive;
  logic [DPS_DATA_W-1:0] memData;
  logic [DPS_DATA_W-1:0] pipeData;
  logic [DPS_DATA_W-1:0] next_pipeData;
  logic next_powerDown;

  // access decode from the inputs sampled at this edge
  always_comb
  begin
    selected = ~chipSelectN & chipSelectP;
    laneOn = {~highLaneEnableN, ~lowLaneEnableN};
    doWrite = selected & ~readWrite;
    doRead = selected & readWrite;
    laneWe = laneOn & {DPS_LANES{doWrite}};
    laneRead = laneOn & {DPS_LANES{doRead}};
    maskedAddr = maskAddr(wordAddress);
  end

  // address counter: rewind, load, hold or advance, selects not consulted
  always_comb
  begin
    next_rewindAddr = rewindAddr;
    if (!counterRewindN)
      addrUsed = rewindAddr;
    else if (!addressLoadStrobeN)
    begin
      addrUsed = maskedAddr;
      next_rewindAddr = maskedAddr;
    end
    else if (!counterAdvanceEnableN)
      addrUsed = maskAddr(currentAddress + 1'b1);
    else
      addrUsed = currentAddress;
    next_currentAddress = addrUsed;
  end

  // counter state, frozen while ce is low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      currentAddress <= DPS_ADDR_RST;
    else if (ce)
      currentAddress <= next_currentAddress;
  end

  // rewind target has no reset: undefined until the first strobe load
  always_ff @(posedge clk)
  begin
    if (ce)
      rewindAddr <= next_rewindAddr;
  end

  // array access at the address chosen this edge
  dps_mem #(
    .AW(DPS_ADDR_W),
    .DW(DPS_DATA_W)
  ) u_mem (
    .clk(clk),
    .ce(ce),
    .addr(addrUsed),
    .laneWe(laneWe),
    .re(doRead),
    .wdata(dataLinesIn),
    .rdata(memData)
  );

  // lane drive pipeline and output data register
  always_comb
  begin
    next_driveStage1 = laneRead;
    next_driveStage2 = driveStage1;
    next_pipeData = memData;
    next_powerDown = ~selected;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      driveStage1 <= DPS_LANE_RST;
      driveStage2 <= DPS_LANE_RST;
      pipeData <= DPS_DATA_RST;
      powerDown <= DPS_PDOWN_RST;
    end
    else if (ce)
    begin
      driveStage1 <= next_driveStage1;
      driveStage2 <= next_driveStage2;
      pipeData <= next_pipeData;
      powerDown <= next_powerDown;
    end
  end

  // mode picks the stage; output enable gates drive with no clock
  assign laneDrive = outputModeSelect ? driveStage2 : driveStage1;
  assign dataLinesOut = outputModeSelect ? pipeData : memData;
  assign dataLinesOe = {{DPS_LANE_W{laneDrive[1] & ~outputEnableN}},
                        {DPS_LANE_W{laneDrive[0] & ~outputEnableN}}};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_flowDesel;
    ce && !selected && !outputModeSelect;
  endsequence

  sequence s_pipeDesel;
    ce && !selected && outputModeSelect ##1 ce && outputModeSelect;
  endsequence

  sequence s_flowReadBoth;
    ce && !outputModeSelect && doRead && laneOn == 2'h3;
  endsequence

  a_flow_deselect_float: assert property (
    s_flowDesel ##1 !outputModeSelect |-> dataLinesOe == 18'h00000)
    else $error("lanes driven after deselect in flow mode");

  a_pipe_deselect_two: assert property (
    s_pipeDesel |=> dataLinesOe == 18'h00000)
    else $error("lanes driven two cycles after pipelined deselect");

  a_oe_forces_float: assert property (
    outputEnableN |-> dataLinesOe == 18'h00000)
    else $error("lanes driven while output enable is high");

  a_lane_mapping: assert property (
    (dataLinesOe[8:0] == 9'h000 || dataLinesOe[8:0] == 9'h1FF) &&
    (dataLinesOe[17:9] == 9'h000 || dataLinesOe[17:9] == 9'h1FF))
    else $error("lane enable split inside a lane");

  a_lane_split: assert property (
    ce && !outputModeSelect && doRead ##1 !outputEnableN && !outputModeSelect
      |-> dataLinesOe == {{9{$past(!highLaneEnableN)}},
                          {9{$past(!lowLaneEnableN)}}})
    else $error("read lane drive does not follow its lane enable");

  a_flow_read_drive: assert property (
    s_flowReadBoth ##1 (!outputEnableN && !outputModeSelect)
      |-> dataLinesOe == 18'h3FFFF)
    else $error("flow read did not drive both lanes next cycle");

  a_load_address: assert property (
    ce && counterRewindN && !addressLoadStrobeN
      |=> currentAddress == $past(maskedAddr))
    else $error("strobe did not load external address");

  a_hold_address: assert property (
    ce && counterRewindN && addressLoadStrobeN && counterAdvanceEnableN
      |=> $stable(currentAddress))
    else $error("counter moved while held");

  a_advance_address: assert property (
    ce && counterRewindN && addressLoadStrobeN && !counterAdvanceEnableN
      |=> currentAddress == maskAddr($past(currentAddress) + 1'b1))
    else $error("counter did not advance by one");

  a_rewind_address: assert property (
    ce && !counterRewindN |=> currentAddress == $past(rewindAddr))
    else $error("rewind did not return to last loaded address");

  a_freeze_on_ce: assert property (
    !ce |=> $stable(currentAddress) && $stable(powerDown))
    else $error("state changed while clock enable low");
endmodule // dps_port

// ---- verification/dps_host_model.sv ----
// host-side pin model: resolves the shared data lines of one port
`timescale 1ns/100ps
module dps_host_model
  import dps_pkg::*;
(
  input wire logic clk,                        // port clock
  input wire logic hostDrive,                  // host drives the lines
  input wire logic [DPS_DATA_W-1:0] hostData,  // host value
  input wire logic [DPS_DATA_W-1:0] portData,  // port output side
  input wire logic [DPS_DATA_W-1:0] portOe,    // port drive enable
  output logic [DPS_DATA_W-1:0] pinLevel       // resolved wire level
);
  logic [DPS_DATA_W-1:0] lastLevel = '0;
  // undriven bits show the inverse of the last level, never a stale copy
  always_comb
  begin
    for (int i = 0; i < DPS_DATA_W; i++)
      pinLevel[i] = portOe[i] ? portData[i] :
                    hostDrive ? hostData[i] : ~lastLevel[i];
  end
  // remember the wire once per cycle
  always_ff @(posedge clk)
    lastLevel <= pinLevel;
endmodule // dps_host_model

// ---- verification/dual_port_sync_sram_port_bench.sv ----
// self-checking bench: flow and pipelined ports side by side
`timescale 1ns/100ps
module dual_port_sync_sram_port_bench;
  import dps_pkg::*;
  logic clk = 0, nrst = 0, csN = 1, csP = 0, rw = 1, oeN = 0, hiN = 1;
  logic loN = 1, strN = 1, advN = 1, rewN = 1, hostDrive = 0;
  logic [17:0] addr = '0, hostData = '0, rewAddr = '0, refAddr = '0;
  logic [17:0] pinF, pinP, outF, outP, oeF, oeP, curF, curP, fData, pData;
  logic pdF, pdP, expPd = 1, fKnown = 0, pKnown = 0;
  logic ce = 1, ceReq = 1;
  // pipelined instance is the smaller variant: address bit 17 ignored
  localparam logic [17:0] PIPE_MASK = 18'h1FFFF;
  logic [1:0] fLane = 0, pLane = 0;
  logic [17:0] mem [int];
  int errors = 0, checks = 0;
  always #10 clk = ~clk;
  // mode held static per instance: flow here, pipelined below
  dps_port u_dut (.clk(clk), .nrst(nrst), .ce(ce),
    .outputModeSelect(1'b0), .chipSelectN(csN), .chipSelectP(csP),
    .readWrite(rw), .outputEnableN(oeN), .highLaneEnableN(hiN),
    .lowLaneEnableN(loN), .addressLoadStrobeN(strN),
    .counterAdvanceEnableN(advN), .counterRewindN(rewN),
    .wordAddress(addr), .dataLinesIn(pinF), .dataLinesOut(outF),
    .dataLinesOe(oeF), .currentAddress(curF), .powerDown(pdF));
  dps_port #(.ADDR_USED(17)) u_dutPipe (.clk(clk), .nrst(nrst), .ce(ce),
    .outputModeSelect(1'b1), .chipSelectN(csN), .chipSelectP(csP),
    .readWrite(rw), .outputEnableN(oeN), .highLaneEnableN(hiN),
    .lowLaneEnableN(loN), .addressLoadStrobeN(strN),
    .counterAdvanceEnableN(advN), .counterRewindN(rewN),
    .wordAddress(addr), .dataLinesIn(pinP), .dataLinesOut(outP),
    .dataLinesOe(oeP), .currentAddress(curP), .powerDown(pdP));
  dps_host_model u_hostF (.clk(clk), .hostDrive(hostDrive),
    .hostData(hostData), .portData(outF), .portOe(oeF), .pinLevel(pinF));
  dps_host_model u_hostP (.clk(clk), .hostDrive(hostDrive),
    .hostData(hostData), .portData(outP), .portOe(oeP), .pinLevel(pinP));
  // lane enables to per-bit mask
  function automatic logic [17:0] laneMask(input logic [1:0] l);
    return {{9{l[1]}}, {9{l[0]}}};
  endfunction
  // compare and count
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one clock of stimulus, reference update and checks after the edge
  task automatic cycle(input logic cn, cp, r, h, l, s, v, w,
                       input logic [17:0] a, input logic [17:0] d);
    logic sel;
    logic [17:0] m;
    begin
      sel = !cn && cp;
      // a clock-enable-low edge leaves every expectation as it was
      if (ceReq)
      begin
        if (!w)
          refAddr = rewAddr;
        else if (!s)
        begin
          refAddr = a;
          rewAddr = a;
        end
        else if (!v)
          refAddr = refAddr + 18'h1;
        pLane = fLane;
        pData = fData;
        pKnown = fKnown;
        fLane = (sel && r) ? {!h, !l} : 2'b00;
        fKnown = mem.exists(refAddr);
        fData = fKnown ? mem[refAddr] : '0;
        m = laneMask({!h, !l});
        if (sel && !r && (fKnown || m == 18'h3FFFF))
          mem[refAddr] = (d & m) | (fData & ~m);
        expPd = !sel;
      end
      ce = ceReq;
      {csN, csP, rw, hiN, loN, strN, advN, rewN} = {cn, cp, r, h, l, s, v, w};
      addr = a;
      hostData = d;
      hostDrive = sel && !r;
      oeN = sel && !r;
      @(posedge clk);
      #2;
      chk(curF, refAddr);
      chk(curP, refAddr & PIPE_MASK);
      chk({17'h0, pdF}, {17'h0, expPd});
      chk({17'h0, pdP}, {17'h0, expPd});
      chk(oeF, laneMask(fLane) & {18{!oeN}});
      chk(oeP, laneMask(pLane) & {18{!oeN}});
      m = laneMask(fLane) & {18{!oeN}};
      if (fKnown)
        chk(pinF & m, fData & m);
      m = laneMask(pLane) & {18{!oeN}};
      if (pKnown)
        chk(pinP & m, pData & m);
      oeN = 1'b1;
      #1;
      chk(oeF | oeP, 18'h0);
    end
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'h6020));
    repeat (6) @(posedge clk);
    #3;
    chk(oeF | oeP | curF, 18'h0);
    chk({17'h0, pdF & pdP}, 18'h1);
    nrst = 1;
    cycle(0, 1, 0, 0, 0, 0, 1, 1, 18'h0, 18'($urandom));
    for (int i = 1; i < 16; i++)
      cycle(0, 1, 0, 0, 0, 1, 0, 1, 18'h0, 18'($urandom));
    $display("test fill done");
    for (int k = 0; k < 4; k++)
    begin
      cycle(0, 1, 0, k[1], k[0], 0, 1, 1, 18'h3, 18'($urandom));
      cycle(0, 1, 1, k[1], k[0], 1, 1, 1, 18'h0, 18'h0);
    end
    $display("test lanes done");
    cycle(1, 1, 1, 0, 0, 0, 1, 1, 18'h20007, 18'h0);
    cycle(1, 1, 1, 0, 0, 0, 1, 1, 18'h5, 18'h0);
    repeat (3) cycle(0, 0, 1, 0, 0, 1, 0, 1, 18'h0, 18'h0);
    cycle(0, 1, 1, 0, 0, 0, 0, 0, 18'h9, 18'h0);
    cycle(0, 1, 1, 0, 0, 1, 1, 1, 18'h0, 18'h0);
    cycle(1, 0, 1, 0, 0, 1, 0, 0, 18'h0, 18'h0);
    $display("test burst done");
    for (int i = 0; i < 400; i++)
    begin
      ceReq = $urandom % 8 != 0;
      cycle($urandom % 4 == 0, $urandom % 4 != 0, 1'($urandom),
            1'($urandom), 1'($urandom), $urandom % 3 != 0, 1'($urandom),
            $urandom % 8 != 0, 18'($urandom % 16), 18'($urandom));
    end
    $display("test random done");
    wrap_up();
  end
  // guard against a hang
  initial
  begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule // dual_port_sync_sram_port_bench
